// >>> hdl/pwr_seq_defs.svh
// constants for the power state and domain controller
// How it works
// - combined domain states always form a legal semantic
// - every processing element tracked on its own
// - memory stays available while distributor powered
// - distributor off: wakes go straight to controller
// - deep sleep: wake timer wakes chosen elements
// - idle keeps power, resumes on interrupt or debug
// - debug access only in run and idle standby
// - sleep loses state, wakes to reset vector
// - off ignores interrupts, wakes only on request
// - B and C keep every domain on
// - D: local timer off, sleeper wakes on interrupt
// - E: sleeper wakes on system timer or event
// - H: sleeper wakes on own timer or events
// - I: idle with timer off resumes on interrupt
// - F some off; G everything down
// - local timer on in run, off in off
// - distributor on if any runs or idles
// - shared timers off only when all off
// - only enabled direct-type interrupts wake sleepers
// - edge wake events held until delivered
`ifndef PWR_SEQ_DEFS_SVH
`define PWR_SEQ_DEFS_SVH
// ------------------------------------------------------------
// sizes and encodings
// ------------------------------------------------------------
`define PE_COUNT       4
`define PE_STATE_W     3
`define ST_RUN         3'h0
`define ST_IDLE_SBY    3'h1
`define ST_IDLE_RET    3'h2
`define ST_SLEEP       3'h3
`define ST_OFF         3'h4
`define ST_WAKING      3'h5
// ------------------------------------------------------------
// timing: domain settle time before a dependent is released
// ------------------------------------------------------------
`define SETTLE_NS      100
`define CLK_NS         10
`define SETTLE_CYC     ((`SETTLE_NS + `CLK_NS - 1) / `CLK_NS)
`define SETTLE_W       4
`define DEEP_WAKE_MASK 4'h1
`endif

// >>> hdl/pwr_seq_pkg.sv
// types for the power state and domain controller
`include "pwr_seq_defs.svh"
package pwr_seq_pkg;
  // per-element power state as tracked
  typedef logic [`PE_STATE_W-1:0] pe_state_t;
  // one request from an element or software
  typedef struct packed {
    logic       valid;      // one-cycle request
    logic [1:0] target;     // 0 run 1 idle standby 2 idle retention 3 sleep
    logic       toOff;      // request off instead of target
    logic       timerOff;   // let local timer go down in idle or sleep
    logic       distOff;    // let distributor go down if allowed
  } pe_req_t;
  // wake inputs seen for one element
  typedef struct packed {
    logic anyIrq;    // any interrupt pending
    logic wakeIrq;   // enabled wake-type interrupt
    logic localTmr;  // own timer expired
    logic debugReq;  // external_debug_request
    logic powerOn;   // explicit power-up request
  } pe_wake_t;
  // shared domain power state
  typedef struct packed {
    logic distOn;
    logic timersOn;
    logic memAvail;
  } dom_t;
endpackage

// >>> hdl/wake_edge_hold.sv
// holds edge wake events until delivered as pending interrupts
`timescale 1ns/1ps
`default_nettype none
module wake_edge_hold (
  input  wire logic core_clk,
  input  wire logic rstn,
  input  wire logic evtPin,     // asynchronous wake pin
  input  wire logic delivered,  // distributor took the interrupt
  output logic      evtSeen,    // synchronised edge, one cycle
  output logic      pending     // held event
);
  import pwr_seq_pkg::*;
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic held;
  } hold_t;
  hold_t st_r;  // state
  hold_t st_nxt; // next state
  // ------------------------------------------------------------
  // sync and sticky hold
  // ------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = evtPin;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    // set wins over clear
    if (st_r.s2 && !st_r.s3) begin
      st_nxt.held = 1'b1;
    end else if (delivered) begin
      st_nxt.held = 1'b0;
    end
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign evtSeen = st_r.s2 & ~st_r.s3;
  assign pending = st_r.held;
endmodule
`default_nettype wire

// >>> hdl/pe_power_fsm.sv
// power state tracker for one processing element
`timescale 1ns/1ps
`default_nettype none
`include "pwr_seq_defs.svh"
module pe_power_fsm (
  input  wire logic                 core_clk,
  input  wire logic                 rstn,
  input  wire pwr_seq_pkg::pe_req_t  req,
  input  wire pwr_seq_pkg::pe_wake_t wake,
  input  wire logic                 sysWake,   // timer or system event, distributor off
  input  wire logic                 allowDist, // distributor is on, wake interrupts count
  input  wire logic                 domReady,  // shared domains up and settled
  output pwr_seq_pkg::pe_state_t     state,
  output logic                      tmrOn,
  output logic                      wantDom    // waking, needs shared domains
);
  import pwr_seq_pkg::*;
  typedef struct packed {
    pe_state_t st;
    logic      tmr;
  } fsm_t;
  fsm_t s_r;   // state
  fsm_t s_nxt; // next state
  // ------------------------------------------------------------
  // transitions
  // ------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    case (s_r.st)
      `ST_RUN: begin
        s_nxt.tmr = 1'b1;
        if (req.valid) begin
          if (req.toOff) begin
            s_nxt.st  = `ST_OFF;
            s_nxt.tmr = 1'b0;
          end else begin
            case (req.target)
              2'h1:    s_nxt.st = `ST_IDLE_SBY;
              2'h2:    s_nxt.st = `ST_IDLE_RET;
              2'h3:    s_nxt.st = `ST_SLEEP;
              default: s_nxt.st = `ST_RUN;
            endcase
            s_nxt.tmr = (req.target == 2'h0) ? 1'b1 : ~req.timerOff;
          end
        end
      end
      `ST_IDLE_SBY, `ST_IDLE_RET: begin
        // powered, retained; any interrupt or debug resumes
        if (wake.anyIrq || wake.debugReq || (s_r.tmr && wake.localTmr)) begin
          s_nxt.st  = `ST_RUN;
          s_nxt.tmr = 1'b1;
        end
      end
      `ST_SLEEP: begin
        // wake interrupt counts only while distributor on, else system events
        if ((allowDist && wake.wakeIrq) || sysWake || (s_r.tmr && wake.localTmr)) begin
          s_nxt.st = `ST_WAKING;
        end
      end
      `ST_OFF: begin
        s_nxt.tmr = 1'b0;
        if (wake.powerOn) begin
          s_nxt.st = `ST_WAKING;
        end
      end
      `ST_WAKING: begin
        if (domReady) begin
          s_nxt.st  = `ST_RUN;
          s_nxt.tmr = 1'b1;
        end
      end
      default: s_nxt.st = `ST_OFF;
    endcase
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_r <= '{st: `ST_RUN, tmr: 1'b1};
    end else begin
      s_r <= s_nxt;
    end
  end
  assign state   = s_r.st;
  assign tmrOn   = s_r.tmr;
  assign wantDom = (s_r.st == `ST_WAKING);
endmodule
`default_nettype wire

// >>> hdl/power_state_domain_control.sv
// top: per-element power states and shared domain sequencing
`timescale 1ns/1ps
`default_nettype none
`include "pwr_seq_defs.svh"
module power_state_domain_control (
  input  wire logic                  core_clk,
  input  wire logic                  rstn,
  input  wire pwr_seq_pkg::pe_req_t   peReq    [`PE_COUNT],
  input  wire pwr_seq_pkg::pe_wake_t  peWake   [`PE_COUNT],
  input  wire logic                  sysTimerWake, // system wake timer pin
  input  wire logic                  sysEvent,     // other wake pin
  input  wire logic                  irqTaken,     // distributor took held event
  output pwr_seq_pkg::pe_state_t      peState  [`PE_COUNT],
  output logic [`PE_COUNT-1:0]       peTimerOn,
  output logic [`PE_COUNT-1:0]       peDebugOk,
  output logic [`PE_COUNT-1:0]       peResetVec,   // restart from reset vector
  output pwr_seq_pkg::dom_t           dom,
  output logic                       msiAllowed,
  output logic                       wakePending
);
  import pwr_seq_pkg::*;
  // ------------------------------------------------------------
  // top state
  // ------------------------------------------------------------
  typedef struct packed {
    dom_t                  d;
    logic [`SETTLE_W-1:0]  settle;
    logic [`PE_COUNT-1:0]  dbg;
    logic [`PE_COUNT-1:0]  rv;
    logic                  msi;
    logic                  drop;   // distributor power-down asked for
    logic                  pend;   // registered copy of held wake events
  } top_t;
  top_t t_r;   // state
  top_t t_nxt; // next state
  pe_state_t            st    [`PE_COUNT]; // per-element states
  logic [`PE_COUNT-1:0] tmr;               // local timer power
  logic [`PE_COUNT-1:0] want;              // waking elements
  logic                 tEvt, tHeld, eEvt, eHeld; // held edges
  logic                 domReady;          // shared domains settled
  logic                 anyAwake, anyActive, allOff, anyDistOff;
  logic [`PE_COUNT-1:0] sysWakeVec;        // deep wake routing
  localparam logic [`PE_COUNT-1:0] DEEP_MASK = `DEEP_WAKE_MASK; // wake timer targets
  // ------------------------------------------------------------
  // edge wake holders
  // ------------------------------------------------------------
  wake_edge_hold u_tmr (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .evtPin    (sysTimerWake),
    .delivered (irqTaken & t_r.d.distOn),
    .evtSeen   (tEvt),
    .pending   (tHeld)
  );
  wake_edge_hold u_evt (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .evtPin    (sysEvent),
    .delivered (irqTaken & t_r.d.distOn),
    .evtSeen   (eEvt),
    .pending   (eHeld)
  );
  // classify element states
  function automatic logic isActive(input pe_state_t s);
    isActive = (s == `ST_RUN) || (s == `ST_IDLE_SBY) || (s == `ST_IDLE_RET) ||
               (s == `ST_WAKING);
  endfunction
  // ------------------------------------------------------------
  // per-element trackers
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `PE_COUNT; g++) begin : gPe
      // without distributor, wakes go to the controller directly
      assign sysWakeVec[g] = !t_r.d.distOn &&
        (((tEvt | tHeld) && DEEP_MASK[g]) || eEvt);
      pe_power_fsm u_pe (
        .core_clk  (core_clk),
        .rstn      (rstn),
        .req       (peReq[g]),
        .wake      (peWake[g]),
        .sysWake   (sysWakeVec[g]),
        .allowDist (t_r.d.distOn),
        .domReady  (domReady),
        .state     (st[g]),
        .tmrOn     (tmr[g]),
        .wantDom   (want[g])
      );
    end
  endgenerate
  assign domReady = t_r.d.distOn && t_r.d.timersOn && (t_r.settle == '0);
  // ------------------------------------------------------------
  // summary of element states
  // ------------------------------------------------------------
  always_comb begin
    anyActive  = 1'b0;
    allOff     = 1'b1;
    anyDistOff = 1'b0;
    for (int i = 0; i < `PE_COUNT; i++) begin
      if (isActive(st[i])) anyActive = 1'b1;
      if (st[i] != `ST_OFF) allOff = 1'b0;
      if (peReq[i].valid && peReq[i].distOff) anyDistOff = 1'b1;
    end
    anyAwake = !allOff;
  end
  // ------------------------------------------------------------
  // shared domain sequencing
  // ------------------------------------------------------------
  always_comb begin
    t_nxt = t_r;
    t_nxt.d.timersOn = anyAwake;
    if (anyActive || (|want)) begin
      t_nxt.d.distOn = 1'b1;
    end else if (allOff) begin
      t_nxt.d.distOn = 1'b0;
    end else if (t_r.drop) begin
      t_nxt.d.distOn = 1'b0; // only when all sleep or off
    end
    // the request is taken while its element still runs, so keep it
    if (anyDistOff) begin
      t_nxt.drop = 1'b1;
    end else if (|want) begin
      t_nxt.drop = 1'b0;
    end
    t_nxt.pend = tHeld | eHeld;
    t_nxt.d.memAvail = t_nxt.d.distOn;
    t_nxt.msi        = t_nxt.d.distOn;
    // settle count restarts on any domain power-up
    if ((t_nxt.d.distOn && !t_r.d.distOn) || (t_nxt.d.timersOn && !t_r.d.timersOn)) begin
      t_nxt.settle = `SETTLE_W'(`SETTLE_CYC);
    end else if (t_r.settle != '0) begin
      t_nxt.settle = t_r.settle - 1'b1;
    end
    for (int i = 0; i < `PE_COUNT; i++) begin
      t_nxt.dbg[i] = (st[i] == `ST_RUN) || (st[i] == `ST_IDLE_SBY);
      t_nxt.rv[i]  = (st[i] == `ST_WAKING);
    end
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      t_r <= '{d: '{distOn: 1'b1, timersOn: 1'b1, memAvail: 1'b1},
               settle: '0, dbg: '1, rv: '0, msi: 1'b1, drop: 1'b0, pend: 1'b0};
    end else begin
      t_r <= t_nxt;
    end
  end
  // ------------------------------------------------------------
  // outputs, all legal semantics by construction
  // ------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < `PE_COUNT; i++) begin
      peState[i] = st[i];
    end
  end
  assign peTimerOn   = tmr;
  assign peDebugOk   = t_r.dbg;
  assign peResetVec  = t_r.rv;
  assign dom         = t_r.d;
  assign msiAllowed  = t_r.msi;
  assign wakePending = t_r.pend;
endmodule
`default_nettype wire

// >>> test/pwr_seq_chk.sv
// concurrent checks on the power state controller ports
`timescale 1ns/1ps
`default_nettype none
`include "pwr_seq_defs.svh"
module pwr_seq_chk (
  input wire logic                   core_clk,
  input wire logic                   rstn,
  input wire pwr_seq_pkg::pe_wake_t  peWake     [`PE_COUNT],
  input wire pwr_seq_pkg::pe_state_t peState    [`PE_COUNT],
  input wire logic [`PE_COUNT-1:0]   peTimerOn,
  input wire logic [`PE_COUNT-1:0]   peDebugOk,
  input wire logic [`PE_COUNT-1:0]   peResetVec,
  input wire pwr_seq_pkg::dom_t      dom,
  input wire logic                   msiAllowed
);
  import pwr_seq_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // ------------------------------------------------------------
  // summaries over elements
  // ------------------------------------------------------------
  logic act;    // some element runs or idles
  logic allOff; // every element off
  logic up;     // some element run, idle or asleep
  logic tmrBad; // run without timer or off with timer
  // fold element states
  always_comb begin
    act = 1'b0;
    allOff = 1'b1;
    up = 1'b0;
    tmrBad = 1'b0;
    for (int i = 0; i < `PE_COUNT; i++) begin
      act |= peState[i] <= `ST_IDLE_RET;
      allOff &= peState[i] == `ST_OFF;
      up |= peState[i] <= `ST_SLEEP;
      tmrBad |= (peState[i] == `ST_RUN) ? !peTimerOn[i] : (peState[i] == `ST_OFF && peTimerOn[i]);
    end
  end
  // ------------------------------------------------------------
  // shared domain checks
  // ------------------------------------------------------------
  property p_tmr; !tmrBad; endproperty
  a_tmr: assert property (p_tmr)
    else $error("local timer wrong for element state");
  property p_dist; act |-> dom.distOn; endproperty
  a_dist: assert property (p_dist)
    else $error("distributor off while an element is active");
  property p_allOff; allOff [*3] |-> !dom.distOn && !dom.timersOn; endproperty
  a_allOff: assert property (p_allOff)
    else $error("domains left up with every element off");
  property p_timers; up |-> dom.timersOn; endproperty
  a_timers: assert property (p_timers)
    else $error("shared timers off while an element is up");
  property p_mem; dom.distOn |-> dom.memAvail; endproperty
  a_mem: assert property (p_mem)
    else $error("memory gone while distributor up");
  property p_msi; !dom.distOn && !$past(dom.distOn) |-> !msiAllowed; endproperty
  a_msi: assert property (p_msi)
    else $error("messages allowed with distributor down");
  // ------------------------------------------------------------
  // per element checks
  // ------------------------------------------------------------
  for (genvar g = 0; g < `PE_COUNT; g++) begin : g_pe
    property p_dbg;
      peState[g] inside {`ST_IDLE_SBY, `ST_IDLE_RET} && $stable(peState[g])
        |-> peDebugOk[g] == (peState[g] == `ST_IDLE_SBY);
    endproperty
    a_dbg: assert property (p_dbg)
      else $error("debug access wrong in idle");
    property p_vec; peState[g] == `ST_WAKING && $stable(peState[g]) |-> peResetVec[g]; endproperty
    a_vec: assert property (p_vec)
      else $error("woken element not sent to reset vector");
    property p_rel;
      peState[g] == `ST_RUN && $past(peState[g]) == `ST_WAKING
        |-> dom.timersOn && $past(dom.distOn, 10);
    endproperty
    a_rel: assert property (p_rel)
      else $error("element released before domains settled");
    property p_off; peState[g] == `ST_OFF && !peWake[g].powerOn |=> peState[g] == `ST_OFF; endproperty
    a_off: assert property (p_off)
      else $error("off element left off without power request");
  end
  c_distDrop: cover property (dom.distOn ##1 !dom.distOn);
  c_allOff: cover property (allOff && !dom.timersOn);
  c_wake: cover property (peState[0] == `ST_WAKING ##1 peState[0] == `ST_RUN);
endmodule
bind power_state_domain_control pwr_seq_chk chk (
  .core_clk(core_clk), .rstn(rstn), .peWake(peWake), .peState(peState),
  .peTimerOn(peTimerOn), .peDebugOk(peDebugOk), .peResetVec(peResetVec),
  .dom(dom), .msiAllowed(msiAllowed)
);
`default_nettype wire

// >>> test/pwr_partner.sv
// interrupt controller side: takes held wake events late, sends messages
`timescale 1ns/1ps
`default_nettype none
module pwr_partner #(
  parameter int LAT = 40 // cycles before a held event is taken
) (
  input  wire logic              core_clk,
  input  wire logic              rstn,
  input  wire logic              wakePending,
  input  wire pwr_seq_pkg::dom_t dom,
  input  wire logic              msiAllowed,
  output logic                   irqTaken,
  output logic                   msiSend
);
  import pwr_seq_pkg::*;
  int cnt; // cycles an event has been visible
  // count only while the distributor is up to take it
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 0;
    end else if (wakePending && dom.distOn) begin
      cnt <= cnt + 1;
    end else begin
      cnt <= 0;
    end
  end
  assign irqTaken = cnt >= LAT;
  assign msiSend = msiAllowed && cnt[0];
endmodule
`default_nettype wire

// >>> test/power_state_domain_control_bench.sv
// self-checking bench for the power state and domain controller
`timescale 1ns/1ps
`default_nettype none
`include "pwr_seq_defs.svh"
module power_state_domain_control_bench;
  import pwr_seq_pkg::*;
  // ------------------------------------------------------------
  // signals and cases
  // ------------------------------------------------------------
  logic                 core_clk = 1'b0;     // core clock
  logic                 rstn = 1'b0;         // reset, low active
  logic                 sysTimerWake = 1'b0; // wake timer pin
  logic                 sysEvent = 1'b0;     // other wake pin
  logic                 irqTaken, msiAllowed, wakePending, msiSend;
  pe_req_t              peReq [`PE_COUNT];
  pe_wake_t             peWake [`PE_COUNT];
  pe_state_t            peState [`PE_COUNT];
  logic [`PE_COUNT-1:0] peTimerOn, peDebugOk, peResetVec;
  dom_t                 dom;
  int                   bad_count = 0;
  int                   checks_done = 0;
  typedef struct packed {
    logic [1:0] pe;
    logic [1:0] tgt;
    logic       tOff;
    pe_wake_t   wk;
    logic       tmr;
    logic       dbg;
  } row_t;
  // element, target, timer off, waker, timer, debug
  row_t rows [5] = '{'{2'h0, 2'h1, 1'b0, 5'h02, 1'b1, 1'b1}, '{2'h1, 2'h2, 1'b0, 5'h10, 1'b1, 1'b0},
                     '{2'h2, 2'h2, 1'b1, 5'h10, 1'b0, 1'b0}, '{2'h3, 2'h3, 1'b0, 5'h08, 1'b1, 1'b0},
                     '{2'h1, 2'h3, 1'b1, 5'h08, 1'b0, 1'b0}};
  always #5 core_clk = ~core_clk;
  power_state_domain_control dut (.core_clk(core_clk), .rstn(rstn), .peReq(peReq),
    .peWake(peWake), .sysTimerWake(sysTimerWake), .sysEvent(sysEvent), .irqTaken(irqTaken),
    .peState(peState), .peTimerOn(peTimerOn), .peDebugOk(peDebugOk), .peResetVec(peResetVec),
    .dom(dom), .msiAllowed(msiAllowed), .wakePending(wakePending));
  pwr_partner partner (.core_clk(core_clk), .rstn(rstn), .wakePending(wakePending), .dom(dom),
    .msiAllowed(msiAllowed), .irqTaken(irqTaken), .msiSend(msiSend));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // one-cycle request to every element in the mask
  task automatic req(input logic [3:0] m, input logic [1:0] t, input logic o, f, d);
    @(negedge core_clk);
    for (int i = 0; i < `PE_COUNT; i++) if (m[i]) peReq[i] = '{1'b1, t, o, f, d};
    @(negedge core_clk);
    for (int i = 0; i < `PE_COUNT; i++) peReq[i] = '0;
  endtask
  // watched value: element state, then distributor, timers, held event
  function automatic logic [7:0] cur(input int s);
    return s < 4 ? peState[s] : s == 4 ? dom.distOn : s == 5 ? dom.timersOn : wakePending;
  endfunction
  task automatic waitOn(input int s, input logic [7:0] v);
    int n;
    for (n = 0; n < 80 && cur(s) !== v; n++)
      @(negedge core_clk);
    if (n == 80) begin
      bad_count++;
      close_out();
    end else begin
      chk(cur(s), v);
    end
  endtask
  task automatic wk(input int p, input pe_wake_t v);
    @(negedge core_clk);
    peWake[p] = v;
  endtask
  task automatic pin(input logic tmr);
    @(negedge core_clk);
    sysTimerWake = tmr;
    sysEvent = !tmr;
    repeat (4) @(negedge core_clk);
    sysTimerWake = 1'b0;
    sysEvent = 1'b0;
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    row_t r;
    for (int i = 0; i < `PE_COUNT; i++) begin
      peReq[i] = '0;
      peWake[i] = '0;
    end
    repeat (12) @(negedge core_clk);
    rstn = 1'b1;
    foreach (rows[k]) begin
      r = rows[k];
      req(4'h1 << r.pe, r.tgt, 1'b0, r.tOff, 1'b0);
      waitOn(r.pe, r.tgt);
      chk(peTimerOn[r.pe], r.tmr);
      if (r.tgt != 2'h3) begin
        @(negedge core_clk); // debug flag follows the state a cycle later
        chk(peDebugOk[r.pe], r.dbg);
      end else begin
        wk(r.pe, 5'h10);
        repeat (5) @(negedge core_clk);
        chk(peState[r.pe], `ST_SLEEP);
      end
      wk(r.pe, r.wk);
      waitOn(r.pe, `ST_RUN);
      wk(r.pe, '0);
    end
    $display("case table done");
    req(4'h1, 2'h3, 1'b0, 1'b0, 1'b1);
    waitOn(0, `ST_SLEEP);
    req(4'h1, 2'h0, 1'b0, 1'b0, 1'b0);
    repeat (3) @(negedge core_clk);
    chk(peState[0], `ST_SLEEP);
    chk(dom.distOn, 1'b1);
    req(4'he, 2'h3, 1'b0, 1'b1, 1'b1);
    waitOn(4, 1'b0);
    chk(msiAllowed, 1'b0);
    chk(dom.timersOn, 1'b1);
    chk(msiSend, 1'b0);
    wk(2, 5'h08);
    repeat (3) @(negedge core_clk);
    chk(peState[2], `ST_SLEEP);
    wk(2, '0);
    pin(1'b1);
    waitOn(0, `ST_RUN);
    chk(peState[1], `ST_SLEEP);
    chk(wakePending, 1'b1);
    waitOn(6, 1'b0);
    req(4'h1, 2'h3, 1'b0, 1'b0, 1'b1);
    waitOn(4, 1'b0);
    wk(0, 5'h04);
    waitOn(0, `ST_RUN);
    wk(0, '0);
    req(4'h1, 2'h3, 1'b0, 1'b0, 1'b1);
    waitOn(4, 1'b0);
    pin(1'b0);
    for (int i = 0; i < `PE_COUNT; i++) waitOn(i, `ST_RUN);
    $display("deep sleep done");
    req(4'h8, 2'h0, 1'b1, 1'b0, 1'b0);
    waitOn(3, `ST_OFF);
    chk(peTimerOn[3], 1'b0);
    wk(3, 5'h18);
    repeat (5) @(negedge core_clk);
    chk(peState[3], `ST_OFF);
    chk(dom.distOn, 1'b1);
    wk(3, '0);
    req(4'h7, 2'h0, 1'b1, 1'b0, 1'b0);
    waitOn(5, 1'b0);
    chk(dom.distOn, 1'b0);
    wk(1, 5'h01);
    waitOn(1, `ST_WAKING);
    @(negedge core_clk);
    chk(peResetVec[1], 1'b1);
    waitOn(1, `ST_RUN);
    chk(dom.timersOn, 1'b1);
    wk(1, '0);
    $display("off states done");
    @(negedge core_clk);
    rstn = 1'b0;
    #1;
    chk(peState[3], `ST_RUN);
    chk({dom, msiAllowed}, 4'hf);
    chk({peTimerOn, peDebugOk}, 8'hff);
    repeat (2) @(negedge core_clk);
    rstn = 1'b1;
    $display("reset done");
    close_out();
  end
endmodule
`default_nettype wire
